// ==== hw/rtcaw_map.svh ====
// Purpose: Register map, field positions, reset values and timing counts
// Assumes: Byte-wide registers at the printed addresses
// Notes: Included by the package and by the design
//
// What this block does
// - Alarm month, date, hour, minute, second and controls live at 0x0A-0x0E.
// - Five repeat bits pick fields to match: second, minute, hour, day, month.
// - Any undefined repeat code behaves as once per second.
// - A match under the repeat criteria sets the alarm flag.
// - Alarm match with alarm enable set and square wave off pulls pin low.
// - Alarm flag is withheld while the pointer rests on the flag register.
// - Reading flags releases the alarm pin; cleared flag shows on next read.
// - On battery the alarm pulls the pin only with both enables set.
// - Watchdog register holds five-bit multiplier and two-bit resolution code.
// - Timeout is multiplier times resolution; expiry sets flag and, with square wave off, pulls pin.
// - Any write to the watchdog register restarts the timeout.
// - Writing zero releases the watchdog pin and disables the watchdog.
// - Reading the flag register clears the watchdog flag in bit 7.
// - Every power-up clears the watchdog register.
// - A programmed watchdog denies the frequency test output.
// - Rate select in 0x13 upper nibble picks square wave frequency.
// - Square wave enable routes the square wave onto the pin.
// - Century enable lets the century bit invert at each century rollover.
// - With all modes off the pin follows the output level bit.
// - First power-up clears enables and sets stop, output and halt bits.
// - Later power-up sets halt, clears test, watchdog and both flags, keeps the rest.
// - Frequency test toggles the pin at 512 Hz when oscillator runs.
// - Flag register holds watchdog flag bit 7, alarm flag bit 6.
`ifndef RTCAW_MAP_SVH
`define RTCAW_MAP_SVH
`define RTCAW_A_SEC 8'h01
`define RTCAW_A_CENT 8'h03
`define RTCAW_A_CTRL 8'h08
`define RTCAW_A_WDOG 8'h09
`define RTCAW_A_AMON 8'h0a
`define RTCAW_A_ADATE 8'h0b
`define RTCAW_A_AHOUR 8'h0c
`define RTCAW_A_AMIN 8'h0d
`define RTCAW_A_ASEC 8'h0e
`define RTCAW_A_FLAGS 8'h0f
`define RTCAW_A_SQW 8'h13
`define RTCAW_B_ST 7
`define RTCAW_B_CEB 7
`define RTCAW_B_CB 6
`define RTCAW_B_OUT 7
`define RTCAW_B_FT 6
`define RTCAW_B_AFE 7
`define RTCAW_B_SQUARE_WAVE_ENABLE 6
`define RTCAW_B_ABE 5
`define RTCAW_B_RPT4 7
`define RTCAW_B_RPT5 6
`define RTCAW_B_RPT3 7
`define RTCAW_B_HT 6
`define RTCAW_B_RPT2 7
`define RTCAW_B_RPT1 7
`define RTCAW_B_WDF 7
`define RTCAW_B_AF 6
`define RTCAW_WDOG_MASK 8'h7f
`define RTCAW_RST_WDOG 8'h00
`define RTCAW_RST_CTRL 8'h80
`define RTCAW_RST_AHOUR 8'h40
`define RTCAW_RST_BYTE 8'h00
`define RTCAW_OSC_HZ 32768
`define RTCAW_WD_BASE_DEN 16
`define RTCAW_FT_HZ 512
`endif

// ==== hw/rtcaw_pkg.sv ====
// Purpose: Types shared by the alarm, watchdog and output block
// Assumes: Constants come from rtcaw_map.svh
// Notes: Time fields are BCD as kept by the time counters
`default_nettype none
`include "rtcaw_map.svh"
package rtcaw_pkg;
  typedef struct packed {
    logic [4:0] month;
    logic [5:0] date;
    logic [5:0] hour;
    logic [6:0] minute;
    logic [6:0] second;
  } rtcaw_time_type;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] pointer;
  } rtcaw_req_type;
  typedef enum logic [1:0] {WD_OFF, WD_RUN, WD_FIRED} rtcaw_wd_type;
  typedef enum logic [2:0] {
    SRC_SQW, SRC_IRQ, SRC_FT, SRC_OUT
  } rtcaw_src_type;
endpackage
`default_nettype wire

// ==== hw/rtcaw_top.sv ====
// Purpose: Alarm, watchdog, square wave, century and output pin logic
// Assumes: Bus engine presents one-cycle read and write strobes
// Notes: Oscillator is sampled and its edges found on CLOCK_I
`default_nettype none
`include "rtcaw_map.svh"
module rtcaw_top #(
  parameter int OSC_HZ = `RTCAW_OSC_HZ
) (
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  input wire logic FIRST_POWER_I,
  input wire logic BATTERY_I,
  input wire logic OSC_32K_I,
  input wire logic SEC_TICK_I,
  input wire logic CENTURY_ROLL_I,
  input wire rtcaw_pkg::rtcaw_time_type TIME_I,
  input wire rtcaw_pkg::rtcaw_req_type REG_REQ_I,
  output logic [7:0] REG_RDATA_O,
  output logic MFO_OUT_O,
  output logic MFO_OE_O
);
  import rtcaw_pkg::*;

  localparam int WD_OSC_CYC = OSC_HZ / `RTCAW_WD_BASE_DEN;
  localparam int PRE_W = $clog2(WD_OSC_CYC);
  localparam int DIV_W = $clog2(OSC_HZ);
  localparam int FT_BIT = $clog2(OSC_HZ / `RTCAW_FT_HZ) - 1;
  // Divider keeps at least 15 stages so every rate code has a tap
  localparam int DIV_N = DIV_W > 15 ? DIV_W : 15;

  if (OSC_HZ < 4096 || (1 << DIV_W) != OSC_HZ) begin : g_osc_chk
    $error("OSC_HZ must be a power of two of at least 4096");
  end

  // ----------------------------------------------------------
  // Oscillator sampling
  // ----------------------------------------------------------
  logic osc_s1, osc_s2, osc_s3, osc_lvl;
  logic [DIV_N-1:0] div;
  logic [PRE_W-1:0] wd_pre;
  wire osc_agree = osc_s2 == osc_s3;
  wire osc_rise = osc_agree && osc_s3 && !osc_lvl;
  wire sixteenth = osc_rise && (&wd_pre);

  always_ff @(posedge CLOCK_I) begin
    osc_s1 <= OSC_32K_I;
    osc_s2 <= osc_s1;
    osc_s3 <= osc_s2;
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      osc_lvl <= 1'b0;
      div <= '0;
    end else begin
      osc_lvl <= osc_agree ? osc_s3 : osc_lvl;
      div <= osc_rise ? div + 1'b1 : div;
    end
  end

  // ----------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------
  logic st;
  logic [1:0] cent;
  logic [7:0] ctrl, wdog, amon, adate, ahour, amin, asec;
  logic [3:0] sqw_rate;
  logic af, af_pend, watchdog_flag, wd_irq;
  wire rd = REG_REQ_I.rd;
  wire wr = REG_REQ_I.wr;
  wire [7:0] ad = REG_REQ_I.addr;
  wire [7:0] wd = REG_REQ_I.wdata;
  wire wr_sec = wr && ad == `RTCAW_A_SEC;
  wire wr_cent = wr && ad == `RTCAW_A_CENT;
  wire wr_ctrl = wr && ad == `RTCAW_A_CTRL;
  wire wr_wdog = wr && ad == `RTCAW_A_WDOG;
  wire wr_amon = wr && ad == `RTCAW_A_AMON;
  wire wr_adate = wr && ad == `RTCAW_A_ADATE;
  wire wr_ahour = wr && ad == `RTCAW_A_AHOUR;
  wire wr_amin = wr && ad == `RTCAW_A_AMIN;
  wire wr_asec = wr && ad == `RTCAW_A_ASEC;
  wire wr_sqw = wr && ad == `RTCAW_A_SQW;
  wire flag_rd = rd && ad == `RTCAW_A_FLAGS;
  wire afe = amon[`RTCAW_B_AFE];
  wire square_wave_enable = amon[`RTCAW_B_SQUARE_WAVE_ENABLE];
  wire abe = amon[`RTCAW_B_ABE];
  wire ft = ctrl[`RTCAW_B_FT];
  wire wd_on = wdog != `RTCAW_RST_WDOG;

  // ----------------------------------------------------------
  // Register file and power-up values
  // ----------------------------------------------------------
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      wdog <= `RTCAW_RST_WDOG;
      ctrl[`RTCAW_B_FT] <= 1'b0;
      ahour[`RTCAW_B_HT] <= 1'b1;
      if (FIRST_POWER_I) begin
        st <= 1'b1;
        ctrl <= `RTCAW_RST_CTRL;
        amon <= `RTCAW_RST_BYTE;
        ahour <= `RTCAW_RST_AHOUR;
        adate <= `RTCAW_RST_BYTE;
        amin <= `RTCAW_RST_BYTE;
        asec <= `RTCAW_RST_BYTE;
        sqw_rate <= 4'h0;
      end
    end else begin
      if (wr_sec) st <= wd[`RTCAW_B_ST];
      if (wr_ctrl) ctrl <= wd;
      if (wr_wdog) wdog <= wd & `RTCAW_WDOG_MASK;
      if (wr_amon) amon <= wd;
      if (wr_adate) adate <= wd;
      if (wr_ahour) ahour <= wd;
      if (wr_amin) amin <= wd;
      if (wr_asec) asec <= wd;
      if (wr_sqw) sqw_rate <= wd[7:4];
    end
  end

  // ----------------------------------------------------------
  // Century bit
  // ----------------------------------------------------------
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      if (FIRST_POWER_I) cent <= 2'b00;
    end else if (wr_cent) begin
      cent <= wd[7:6];
    end else if (CENTURY_ROLL_I && cent[1]) begin
      cent[0] <= !cent[0];
    end
  end

  // ----------------------------------------------------------
  // Alarm compare
  // ----------------------------------------------------------
  // Returns which of month, date, hour, minute, second must match
  function automatic logic [4:0] rtcaw_need(input logic [4:0] rpt);
    case (rpt)
      5'h1f: rtcaw_need = 5'h00;
      5'h1e: rtcaw_need = 5'h01;
      5'h1c: rtcaw_need = 5'h03;
      5'h18: rtcaw_need = 5'h07;
      5'h10: rtcaw_need = 5'h0f;
      5'h00: rtcaw_need = 5'h1f;
      default: rtcaw_need = 5'h00;
    endcase
  endfunction

  wire [4:0] rpt = {adate[`RTCAW_B_RPT5], adate[`RTCAW_B_RPT4],
    ahour[`RTCAW_B_RPT3], amin[`RTCAW_B_RPT2], asec[`RTCAW_B_RPT1]};
  wire [4:0] need = rtcaw_need(rpt);
  wire [4:0] eq = {TIME_I.month == amon[4:0],
    TIME_I.date == adate[5:0], TIME_I.hour == ahour[5:0],
    TIME_I.minute == amin[6:0], TIME_I.second == asec[6:0]};
  wire hit = SEC_TICK_I && (&(eq | ~need));
  wire ptr_on = REG_REQ_I.pointer == `RTCAW_A_FLAGS;
  wire alarm_set = (hit || af_pend) && !ptr_on;
  wire next_af = alarm_set || (af && !flag_rd);
  wire alarm_act = af && afe && (!BATTERY_I || abe);

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      af <= 1'b0;
      af_pend <= 1'b0;
    end else begin
      af <= next_af;
      af_pend <= ptr_on && (af_pend || hit);
    end
  end

  // ----------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------
  // Prescaler restarts with every watchdog write so the period is exact
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      wd_pre <= '0;
    end else if (wr_wdog) begin
      wd_pre <= '0;
    end else if (osc_rise) begin
      wd_pre <= wd_pre + 1'b1;
    end
  end

  rtcaw_wd_type wd_state;
  logic [11:0] wd_cnt;
  wire [11:0] wd_target = 12'({7'h00, wdog[6:2]} << {wdog[1:0], 1'b0});
  wire [11:0] wd_cnt_inc = wd_cnt + 12'h001;
  wire wd_hit = wd_cnt_inc == wd_target;
  wire wd_fire = wd_state == WD_RUN && sixteenth && wd_hit;
  wire next_wdf = wd_fire || (watchdog_flag && !flag_rd);

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      wd_state <= WD_OFF;
      wd_cnt <= 12'h000;
      wd_irq <= 1'b0;
      watchdog_flag <= 1'b0;
    end else begin
      watchdog_flag <= next_wdf;
      if (wr_wdog) begin
        wd_cnt <= 12'h000;
        wd_state <= wd[6:2] != 5'h00 ? WD_RUN : WD_OFF;
        wd_irq <= wd == `RTCAW_RST_WDOG ? 1'b0 : wd_irq;
      end else begin
        case (wd_state)
          WD_RUN: begin
            if (wd_fire) begin
              wd_state <= WD_FIRED;
              wd_irq <= 1'b1;
            end else if (sixteenth) begin
              wd_cnt <= wd_cnt_inc;
            end
          end
          WD_FIRED: wd_state <= WD_FIRED;
          WD_OFF: wd_state <= WD_OFF;
          default: wd_state <= WD_OFF;
        endcase
      end
    end
  end

  // ----------------------------------------------------------
  // Pin source selection
  // ----------------------------------------------------------
  wire [3:0] sq_idx = sqw_rate - 4'h1;
  wire sq_lvl = sqw_rate == 4'h0 ? 1'b1 :
    sqw_rate == 4'h1 ? osc_lvl : div[sq_idx];
  wire ft_ok = ft && !afe && !wd_on && !st;
  wire irq = alarm_act || wd_irq;
  rtcaw_src_type sel;
  assign sel = square_wave_enable ? SRC_SQW : irq ? SRC_IRQ :
    ft_ok ? SRC_FT : SRC_OUT;
  wire pin_lvl = sel == SRC_SQW ? sq_lvl :
    sel == SRC_IRQ ? 1'b0 :
    sel == SRC_FT ? div[FT_BIT] :
    ctrl[`RTCAW_B_OUT];

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      MFO_OUT_O <= 1'b0;
      MFO_OE_O <= 1'b0;
    end else begin
      MFO_OUT_O <= 1'b0;
      MFO_OE_O <= !pin_lvl;
    end
  end

  // ----------------------------------------------------------
  // Read data
  // ----------------------------------------------------------
  logic [7:0] rd_mux;
  always_comb begin
    case (ad)
      `RTCAW_A_SEC: rd_mux = {st, 7'h00};
      `RTCAW_A_CENT: rd_mux = {cent, 6'h00};
      `RTCAW_A_CTRL: rd_mux = ctrl;
      `RTCAW_A_WDOG: rd_mux = wdog;
      `RTCAW_A_AMON: rd_mux = amon;
      `RTCAW_A_ADATE: rd_mux = adate;
      `RTCAW_A_AHOUR: rd_mux = ahour;
      `RTCAW_A_AMIN: rd_mux = amin;
      `RTCAW_A_ASEC: rd_mux = asec;
      `RTCAW_A_FLAGS: rd_mux = {watchdog_flag, af, 6'h00};
      `RTCAW_A_SQW: rd_mux = {sqw_rate, 4'h0};
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      REG_RDATA_O <= 8'h00;
    end else if (rd) begin
      REG_RDATA_O <= rd_mux;
    end
  end

  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  default clocking cb_main @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);

  sequence s_wd_fire;
    wd_state == WD_RUN && sixteenth && wd_hit && !wr_wdog;
  endsequence
  sequence s_wd_held;
    wd_irq && watchdog_flag;
  endsequence

  alarm_set_a: assert property (hit && !ptr_on |=> af)
    else $error("alarm match did not set flag");
  alarm_hold_a: assert property (ptr_on && !af && !af_pend
    |=> !af)
    else $error("alarm flag set while pointer on flags");
  flag_read_a: assert property (flag_rd && !alarm_set && !wd_fire
    |=> !af && !watchdog_flag)
    else $error("flag read did not clear flags");
  wd_fire_a: assert property (s_wd_fire |=> s_wd_held)
    else $error("watchdog expiry missed");
  wd_restart_a: assert property (wr_wdog |=> wd_cnt == 12'h000)
    else $error("watchdog write did not restart count");
  wd_zero_a: assert property (wr_wdog && wd == 8'h00
    |=> !wd_irq && wd_state == WD_OFF)
    else $error("zero write did not release watchdog");
  alarm_pin_a: assert property (alarm_act && !square_wave_enable |=> MFO_OE_O)
    else $error("alarm did not pull pin low");
  sqw_pin_a: assert property (square_wave_enable |=> MFO_OE_O == !$past(sq_lvl))
    else $error("pin does not follow square wave");
  out_pin_a: assert property (!square_wave_enable && !irq && !ft
    |=> MFO_OE_O == !$past(ctrl[`RTCAW_B_OUT]))
    else $error("pin does not follow output level");
  century_a: assert property (CENTURY_ROLL_I && cent[1] && !wr_cent
    |=> cent[0] != $past(cent[0]))
    else $error("century bit did not invert");

  sequence s_wd_write;
    wr_wdog;
  endsequence
  sequence s_wd_fresh;
    wd_pre == '0 && wd_cnt == 12'h000;
  endsequence
  wd_pre_a: assert property (s_wd_write |=> s_wd_fresh)
    else $error("watchdog write did not restart prescaler");
  wd_keep_a: assert property (wr_wdog && wd != 8'h00 && wd_irq
    |=> wd_irq)
    else $error("nonzero write released watchdog pin");
  ft_pin_a: assert property (sel == SRC_FT
    |=> MFO_OE_O == !$past(div[FT_BIT]))
    else $error("pin does not follow frequency test");
  wd_deny_a: assert property (wd_on && !square_wave_enable && !irq
    |=> MFO_OE_O == !$past(ctrl[`RTCAW_B_OUT]))
    else $error("frequency test not denied by watchdog");
  flag_data_a: assert property (flag_rd
    |=> REG_RDATA_O == {$past(watchdog_flag), $past(af), 6'h00})
    else $error("flag register read wrong value");
  batt_mask_a: assert property (BATTERY_I && !abe && !wd_irq && !square_wave_enable
    && !ft |=> MFO_OE_O == !$past(ctrl[`RTCAW_B_OUT]))
    else $error("alarm pulled pin on battery without enable");
  sqw_none_a: assert property (square_wave_enable && sqw_rate == 4'h0
    |=> !MFO_OE_O)
    else $error("square wave code zero drove pin");
  alarm_pend_a: assert property (hit && ptr_on |=> af_pend)
    else $error("alarm during pointer hold was lost");
  drain_only_a: assert property (1'b1 |-> !MFO_OUT_O)
    else $error("pin output value not low");
endmodule
`default_nettype wire

// ==== sim/rtcaw_host.sv ====
// Purpose: Host model on the register request port
// Assumes: Requests change at the falling clock edge
// Notes: The pointer rests past each address used
`default_nettype none
module rtcaw_host (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output var rtcaw_pkg::rtcaw_req_type req_o
);
  import rtcaw_pkg::*;
  // ----------
  // Bus cycles
  // ----------
  initial req_o = '0;
  task automatic point(input logic [7:0] a);
    @(negedge clk_i);
    req_o.pointer = a;
  endtask
  task automatic xfer(input logic r, input logic w, input logic [7:0] a,
    input logic [7:0] v);
    @(negedge clk_i);
    req_o = '{r, w, a, v, a};
    @(negedge clk_i);
    req_o = '{1'b0, 1'b0, a, v, a + 8'h01};
  endtask
  // Read data is taken once the registered answer has settled
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    xfer(1'b1, 1'b0, a, 8'h00);
    @(negedge clk_i);
    d = rdata_i;
  endtask
endmodule
`default_nettype wire

// ==== sim/rtcaw_top_tb.sv ====
// Purpose: Self-checking bench for the alarm, watchdog and pin block
// Assumes: Oscillator parameter scaled down to shorten the watchdog
// Notes: Expected values come from the model function and shadow bytes
`default_nettype none
module rtcaw_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rtcaw_pkg::*;
  localparam int OSC = 4096;
  logic clk = 1'b0, rst_n = 1'b0, first = 1'b1, batt = 1'b0;
  logic osc = 1'b0, tick = 1'b0, roll = 1'b0, oe, pin;
  logic [7:0] rdata, d;
  logic [7:0] sh [0:31];
  rtcaw_time_type tm = '0;
  rtcaw_req_type req;
  int fail_count = 0, cmp_count = 0, cyc = 0, n, c;
  int seed = 32'h63512db4;
  rtcaw_top #(.OSC_HZ(OSC)) rtcaw_top_inst (.CLOCK_I(clk), .RST_N_I(rst_n),
    .FIRST_POWER_I(first), .BATTERY_I(batt), .OSC_32K_I(osc),
    .SEC_TICK_I(tick), .CENTURY_ROLL_I(roll), .TIME_I(tm), .REG_REQ_I(req),
    .REG_RDATA_O(rdata), .MFO_OUT_O(pin), .MFO_OE_O(oe));
  rtcaw_host rtcaw_host_inst (.clk_i(clk), .rdata_i(rdata), .req_o(req));
  // -------------
  // Shared tasks
  // -------------
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    rtcaw_host_inst.rd(a, d);
    chk(d, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    rtcaw_host_inst.xfer(1'b0, 1'b1, a, v);
    sh[a[4:0]] = v;
  endtask
  task automatic waitn(input int k);
    repeat (k) @(negedge clk);
  endtask
  // Counts pin changes over k cycles after a short settling gap
  task automatic tog(input int k, output int t);
    logic p;
    waitn(4);
    t = 0;
    p = oe;
    repeat (k) begin
      @(negedge clk);
      if (oe !== p) t++;
      p = oe;
    end
  endtask
  function automatic logic hit(input logic [4:0] r, input logic [4:0] df);
    logic [4:0] ign;
    ign = (r inside {5'h1f, 5'h1e, 5'h1c, 5'h18, 5'h10, 5'h00}) ? r : 5'h1f;
    return (df & ~ign) == 5'h00;
  endfunction
  task automatic setal(input logic [4:0] r, input logic [4:0] df,
    input logic abe, input logic mv);
    wr(8'h0a, {2'b10, abe, 5'h01});
    wr(8'h0b, {r[3], r[4], 6'h02});
    wr(8'h0c, {r[2], 1'b0, 6'h03});
    wr(8'h0d, {r[1], 7'h04});
    wr(8'h0e, {r[0], 7'h05});
    if (mv) rtcaw_host_inst.point(8'h00);
    tm = {5'h01, 6'h02, 6'h03, 7'h04, 7'h05} ^ {4'h0, df[4], 5'h00, df[3],
      5'h00, df[2], 6'h00, df[1], 6'h00, df[0]};
    @(negedge clk);
    tick = 1'b1;
    @(negedge clk);
    tick = 1'b0;
  endtask
  initial forever #4 clk = ~clk;
  initial begin
    #13;
    forever #40 osc = ~osc;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      test_done();
    end
  end
  // -------------
  // Main sequence
  // -------------
  initial begin
    logic [4:0] codes [7];
    logic [4:0] df;
    logic abe, h, e;
    codes = '{5'h1f, 5'h1e, 5'h1c, 5'h18, 5'h10, 5'h00, 5'h01};
    codes[6] = {1'b0, 3'($random(seed)), 1'b1};
    waitn(12);
    rst_n = 1'b1;
    chk({7'h0, oe}, 8'h00);
    chk({7'h0, pin}, 8'h00);
    rc(8'h08, 8'h80);
    rc(8'h09, 8'h00);
    rc(8'h0a, 8'h00);
    rc(8'h0c, 8'h40);
    rc(8'h01, 8'h80);
    wr(8'h10, 8'h5a);
    rc(8'h10, 8'h00);
    rc(8'h0f, 8'h00);
    $display("Reset test done");
    for (int i = 0; i < 7; i++) begin
      for (int f = 0; f < 6; f++) begin
        abe = 1'($random(seed));
        batt = 1'($random(seed));
        df = (f < 5) ? 5'(1 << f) : 5'h00;
        setal(codes[i], df, abe, 1'b1);
        h = hit(codes[i], df);
        e = h & (~batt | abe);
        waitn(3);
        chk({7'h0, oe}, {7'h0, e});
        rc(8'h0f, {1'b0, h, 6'h00});
        waitn(2);
        chk({7'h0, oe}, 8'h00);
        rc(8'h0f, 8'h00);
      end
    end
    batt = 1'b0;
    rc(8'h0b, sh[5'h0b]);
    setal(5'h1f, 5'h00, 1'b0, 1'b0);
    waitn(4);
    chk({7'h0, oe}, 8'h00);
    rtcaw_host_inst.point(8'h00);
    waitn(3);
    chk({7'h0, oe}, 8'h01);
    $display("Alarm test done");
    wr(8'h0a, 8'hc1);
    for (int k = 0; k < 7; k++) begin
      wr(8'h13, {4'(k), 4'h0});
      tog(40 << k, c);
      chk({7'h0, k == 0 ? c == 0 : k == 1 ? c > 14 && c < 18 :
        c > 6 && c < 10}, 8'h01);
    end
    wr(8'h0a, 8'h81);
    waitn(3);
    chk({7'h0, oe}, 8'h01);
    wr(8'h13, 8'h6f);
    rc(8'h13, 8'h60);
    rc(8'h0f, 8'h40);
    rc(8'h0f, 8'h00);
    wr(8'h0a, 8'h00);
    $display("Square wave test done");
    wr(8'h01, 8'h00);
    wr(8'h08, 8'hc0);
    tog(1500, c);
    chk({7'h0, c > 1}, 8'h01);
    wr(8'h09, 8'h7c);
    tog(1500, c);
    chk(8'(c), 8'h00);
    wr(8'h09, 8'h00);
    wr(8'h01, 8'h80);
    tog(1500, c);
    chk(8'(c), 8'h00);
    wr(8'h08, 8'h00);
    waitn(3);
    chk({7'h0, oe}, 8'h01);
    wr(8'h08, 8'h80);
    waitn(3);
    chk({7'h0, oe}, 8'h00);
    $display("Pin mode test done");
    wr(8'h09, 8'h04);
    waitn(2000);
    wr(8'h09, 8'h04);
    waitn(2000);
    chk({7'h0, oe}, 8'h00);
    n = 0;
    while (oe !== 1'b1 && n < 1000) begin
      @(negedge clk);
      n++;
    end
    chk({7'h0, n > OSC * 10 / 16 - 2040 && n < OSC * 10 / 16 - 1960},
      8'h01);
    rc(8'h0f, 8'h80);
    rc(8'h0f, 8'h00);
    rc(8'h09, 8'h04);
    chk({7'h0, oe}, 8'h01);
    wr(8'h09, 8'h00);
    waitn(3);
    chk({7'h0, oe}, 8'h00);
    $display("Watchdog test done");
    for (int j = 1; j >= 0; j--) begin
      wr(8'h03, {1'(j), 7'h05});
      @(negedge clk);
      roll = 1'b1;
      @(negedge clk);
      roll = 1'b0;
      rc(8'h03, {1'(j), 1'(j), 6'h00});
    end
    wr(8'h08, 8'h5f);
    wr(8'h09, 8'h04);
    first = 1'b0;
    rst_n = 1'b0;
    waitn(4);
    rst_n = 1'b1;
    rc(8'h08, 8'h1f);
    rc(8'h09, 8'h00);
    rc(8'h0c, sh[5'h0c] | 8'h40);
    rc(8'h0a, sh[5'h0a]);
    rc(8'h01, sh[5'h01]);
    chk({7'h0, oe}, 8'h01);
    $display("Power-up test done");
    test_done();
  end
endmodule
`default_nettype wire
